// ===== rtl/refresh_hold_arbiter.sv
// Bus hold arbiter with refresh strobe and address enables
//
// Contract
// - Raise hold request when a DMA controller or refresh timer needs bus.
// - Processor acks only after releasing bus; drive buses only after ack.
// - Address enable one low exactly while controller one drives addresses.
// - Address enable two low exactly while controller two drives addresses.
// - Terminal count flag rises when any DMA channel ends its count.
// - Channel ready inactive stretches DMA memory strobes as long as it lasts.
// - Counter is clocked from the separate reference clock input.
// - Counter two output state appears directly on its pin; the code registers it, so the pin follows one enabled clock later.
// - Refresh pulled low only after counter one hold request is acknowledged.
// - Low refresh line selects the refresh entry of the page mapper.
// - Refresh line is also an input; device only pulls it low.
// - Active-high reset clears the arbiter with the DMA controllers.
// - Arbiter runs on system clock; DMA clock is system clock halved.
`timescale 1ns/1ns
module refresh_hold_arbiter (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// DMA controllers and counter
	input wire refresh_hold_pkg::dma_side_t dma_i,
	input wire logic counter_one_out_i,
	input wire logic counter_two_state_i,
	// Pins from outside
	input wire logic hold_ack_in_i,
	input wire logic external_master_n_i,
	input wire logic channel_ready_i,
	input wire logic refresh_n_i,
	input wire logic counter_ref_clock_i,
	// Processor side
	output logic hold_request_out_o,
	// Bus ownership
	output logic addr_enable_ctl_one_n_o,
	output logic addr_enable_ctl_two_n_o,
	output logic upper_addr_oe_o,
	output logic dma_grant_o,
	output logic strobe_stretch_o,
	output logic terminal_count_flag_o,
	// Clocks for DMA and counter
	output logic dma_clk_en_o,
	output logic counter_ref_tick_o,
	output logic counter_two_out_o,
	// Refresh line and mapper select
	output logic refresh_n_o,
	output logic refresh_n_oe_o,
	output logic refresh_sel_o
);

	refresh_hold_pkg::pin_in_t pin_raw;
	refresh_hold_pkg::pin_in_t pin_s;
	refresh_hold_pkg::arb_state_t state;
	refresh_hold_pkg::arb_state_t next_state;
	logic owner_two;
	logic next_owner_two;
	logic refresh_pending;
	logic next_refresh_pending;
	logic counter_one_prev;
	logic [refresh_hold_pkg::REFRESH_CNT_W-1:0] refresh_cnt;
	logic [refresh_hold_pkg::REFRESH_CNT_W-1:0] next_refresh_cnt;
	logic ref_clk_prev;
	logic tc_flag;
	logic next_tc_flag;
	logic dma_clk;
	logic counter_two;
	logic ext_master;
	logic dma_any;
	logic refresh_rise;

	assign pin_raw = '{
		hold_ack: hold_ack_in_i,
		external_master_n: external_master_n_i,
		channel_ready: channel_ready_i,
		refresh_n: refresh_n_i,
		counter_ref_clock: counter_ref_clock_i
	};

	// Pins from outside the clock domain
	pin_sync #(
		.W(refresh_hold_pkg::PIN_W),
		.RST_VAL(refresh_hold_pkg::PIN_RST)
	) u_pin_sync (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.d_i(pin_raw),
		.q_o(pin_s)
	);

	assign ext_master = !pin_s.external_master_n;
	assign dma_any = (dma_i.req_one || dma_i.req_two) && !ext_master;
	assign refresh_rise = counter_one_out_i && !counter_one_prev;

	// Arbiter next state
	always_comb begin
		next_state = state;
		next_owner_two = owner_two;
		next_refresh_cnt = refresh_cnt;
		// Set wins over clear
		next_refresh_pending = refresh_pending;
		if (state == refresh_hold_pkg::ST_RFSH &&
				refresh_cnt == '0) begin
			next_refresh_pending = 1'b0;
		end
		if (refresh_rise) begin
			next_refresh_pending = 1'b1;
		end
		case (state)
			refresh_hold_pkg::ST_IDLE: begin
				if ((refresh_pending || dma_any) &&
						!pin_s.hold_ack) begin
					next_state = refresh_hold_pkg::ST_REQ;
				end
			end
			refresh_hold_pkg::ST_REQ: begin
				if (pin_s.hold_ack && !ext_master) begin
					if (refresh_pending) begin
						next_state = refresh_hold_pkg::ST_RFSH;
						next_refresh_cnt = refresh_hold_pkg::REFRESH_CNT_W'(
							refresh_hold_pkg::REFRESH_CYC - 1);
					end else if (dma_any) begin
						next_state = refresh_hold_pkg::ST_DMA;
						next_owner_two = !dma_i.req_one;
					end else begin
						next_state = refresh_hold_pkg::ST_IDLE;
					end
				end else if (!refresh_pending && !dma_any) begin
					next_state = refresh_hold_pkg::ST_IDLE;
				end
			end
			refresh_hold_pkg::ST_DMA: begin
				if (ext_master || !pin_s.hold_ack ||
						(owner_two ? !dma_i.req_two : !dma_i.req_one)) begin
					next_state = refresh_hold_pkg::ST_IDLE;
				end
			end
			refresh_hold_pkg::ST_RFSH: begin
				if (refresh_cnt == '0 || !pin_s.hold_ack) begin
					next_state = refresh_hold_pkg::ST_IDLE;
				end else begin
					next_refresh_cnt = refresh_cnt - 1'b1;
				end
			end
			default: begin
				next_state = refresh_hold_pkg::ST_IDLE;
			end
		endcase
	end

	// Terminal count flag while a channel owns the bus
	always_comb begin
		next_tc_flag = 1'b0;
		if (state == refresh_hold_pkg::ST_DMA) begin
			next_tc_flag = dma_i.tc_one || dma_i.tc_two;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			state <= refresh_hold_pkg::ST_IDLE;
			owner_two <= refresh_hold_pkg::OWNER_TWO_RST;
			refresh_pending <= 1'b0;
			counter_one_prev <= 1'b0;
			refresh_cnt <= refresh_hold_pkg::REFRESH_CNT_RST;
			ref_clk_prev <= 1'b0;
			tc_flag <= 1'b0;
			dma_clk <= 1'b0;
			counter_two <= 1'b0;
		end else if (ce_i) begin
			state <= next_state;
			owner_two <= next_owner_two;
			refresh_pending <= next_refresh_pending;
			counter_one_prev <= counter_one_out_i;
			refresh_cnt <= next_refresh_cnt;
			ref_clk_prev <= pin_s.counter_ref_clock;
			tc_flag <= next_tc_flag;
			dma_clk <= !dma_clk;
			counter_two <= counter_two_state_i;
		end
	end

	// Outputs
	assign hold_request_out_o = state != refresh_hold_pkg::ST_IDLE;
	assign dma_grant_o = state == refresh_hold_pkg::ST_DMA;
	assign addr_enable_ctl_one_n_o = !(dma_grant_o && !owner_two);
	assign addr_enable_ctl_two_n_o = !(dma_grant_o && owner_two);
	assign upper_addr_oe_o = pin_s.hold_ack && !ext_master;
	assign strobe_stretch_o = dma_grant_o && !pin_s.channel_ready;
	assign terminal_count_flag_o = tc_flag;
	assign dma_clk_en_o = dma_clk;
	assign counter_ref_tick_o = pin_s.counter_ref_clock && !ref_clk_prev;
	assign counter_two_out_o = counter_two;
	assign refresh_n_o = 1'b0;
	assign refresh_n_oe_o = state == refresh_hold_pkg::ST_RFSH;
	assign refresh_sel_o = refresh_n_oe_o || !pin_s.refresh_n;

	property p_hold_cause;
		@(posedge clk_sys_i) disable iff (sys_rst_i || !ce_i)
		$rose(hold_request_out_o) |-> $past(refresh_pending || dma_any);
	endproperty
	a_hold_cause: assert property (p_hold_cause)
		else $error("Hold request raised without a cause");

	property p_aen_after_ack;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		(!addr_enable_ctl_one_n_o || !addr_enable_ctl_two_n_o) |->
			pin_s.hold_ack;
	endproperty
	a_aen_after_ack: assert property (p_aen_after_ack)
		else $error("Address enable without hold acknowledge");

	property p_aen_one;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		!addr_enable_ctl_one_n_o |-> addr_enable_ctl_two_n_o && !owner_two;
	endproperty
	a_aen_one: assert property (p_aen_one)
		else $error("Address enable one with wrong owner");

	property p_aen_two;
		@(posedge clk_sys_i) disable iff (sys_rst_i || !ce_i)
		(state == refresh_hold_pkg::ST_DMA && owner_two && !ext_master &&
			pin_s.hold_ack && dma_i.req_two) |=> !addr_enable_ctl_two_n_o;
	endproperty
	a_aen_two: assert property (p_aen_two)
		else $error("Address enable two dropped while channel two active");

	property p_tc;
		@(posedge clk_sys_i) disable iff (sys_rst_i || !ce_i)
		(dma_grant_o && (dma_i.tc_one || dma_i.tc_two)) |=>
			terminal_count_flag_o;
	endproperty
	a_tc: assert property (p_tc)
		else $error("Terminal count not flagged");

	property p_master_quiet;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		ext_master |-> addr_enable_ctl_one_n_o && addr_enable_ctl_two_n_o &&
			!upper_addr_oe_o;
	endproperty
	a_master_quiet: assert property (p_master_quiet)
		else $error("DMA drives bus during external mastering");

	property p_stretch;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		(dma_grant_o && !pin_s.channel_ready) |-> strobe_stretch_o;
	endproperty
	a_stretch: assert property (p_stretch)
		else $error("Strobe not stretched while channel not ready");

	property p_counter_two;
		@(posedge clk_sys_i) disable iff (sys_rst_i || !ce_i)
		##1 $past(ce_i) |-> counter_two_out_o == $past(counter_two_state_i);
	endproperty
	a_counter_two: assert property (p_counter_two)
		else $error("Counter two output does not follow counter");

	property p_refresh_len;
		@(posedge clk_sys_i) disable iff (sys_rst_i || !ce_i)
		$rose(refresh_n_oe_o) |->
			(refresh_n_oe_o || !pin_s.hold_ack)[*8];
	endproperty
	a_refresh_len: assert property (p_refresh_len)
		else $error("Refresh strobe ended early with acknowledge held");

	property p_refresh_ack;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
		refresh_n_oe_o |-> pin_s.hold_ack && hold_request_out_o &&
			refresh_sel_o;
	endproperty
	a_refresh_ack: assert property (p_refresh_ack)
		else $error("Refresh driven without acknowledged request");

	property p_refresh_bound;
		@(posedge clk_sys_i) disable iff (sys_rst_i || !ce_i)
		$rose(refresh_n_oe_o) |-> ##[1:8] !refresh_n_oe_o;
	endproperty
	a_refresh_bound: assert property (p_refresh_bound)
		else $error("Refresh strobe held too long");

	property p_dma_clk;
		@(posedge clk_sys_i) disable iff (sys_rst_i || !ce_i)
		##1 $past(ce_i) |-> dma_clk_en_o != $past(dma_clk_en_o);
	endproperty
	a_dma_clk: assert property (p_dma_clk)
		else $error("DMA clock not halved");

endmodule

// ===== rtl/refresh_hold_pkg.sv
// Shared constants and carriers for the refresh and hold arbiter
package refresh_hold_pkg;

	// Clock rate and refresh strobe length
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned REFRESH_NS = 32;
	localparam int unsigned REFRESH_CYC =
		(REFRESH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned REFRESH_CNT_W = 4;

	// Pin synchroniser layout and values after reset
	localparam int unsigned PIN_W = 5;
	localparam logic [4:0] PIN_RST = 5'h0e;

	// Values after reset
	localparam logic OWNER_TWO_RST = 1'b0;
	localparam logic [REFRESH_CNT_W-1:0] REFRESH_CNT_RST = 4'h0;

	// Arbiter states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_REQ = 4'h2,
		ST_DMA = 4'h4,
		ST_RFSH = 4'h8
	} arb_state_t;

	// Requests and terminal counts from the two DMA controllers
	typedef struct packed {
		logic req_one;
		logic req_two;
		logic tc_one;
		logic tc_two;
	} dma_side_t;

	// Pins sampled from outside the clock domain
	typedef struct packed {
		logic hold_ack;
		logic external_master_n;
		logic channel_ready;
		logic refresh_n;
		logic counter_ref_clock;
	} pin_in_t;

endpackage

// ===== rtl/pin_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock, reset, enable
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	// Raw and filtered levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// Take a bit once second and third stages agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_q[i] = (s2[i] == s3[i]) ? s3[i] : q_o[i];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			s1 <= RST_VAL;
			s2 <= RST_VAL;
			s3 <= RST_VAL;
			q_o <= RST_VAL;
		end else if (ce_i) begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			q_o <= next_q;
		end
	end

endmodule

// ===== dv/host_cpu_model.sv
// Behavioural host processor that grants the system bus
`timescale 1ns/1ns
module host_cpu_model (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	// Hold handshake and answer delay
	input wire logic hold_request_i,
	input wire logic [3:0] dly_i,
	output logic hold_ack_o
);
	logic [3:0] cnt;
	initial hold_ack_o = 1'b0;
	always @(posedge clk_sys_i) begin
		if (sys_rst_i || !hold_request_i) begin
			hold_ack_o <= 1'b0;
			cnt <= 4'h0;
		end else if (cnt >= dly_i) begin
			hold_ack_o <= 1'b1;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// ===== dv/tb_refresh_hold_arbiter.sv
// Self-checking bench for the refresh and hold arbiter
`timescale 1ns/1ns
module tb_refresh_hold_arbiter;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	refresh_hold_pkg::dma_side_t dma = '0;
	logic cnt_one = 1'b0, cnt_two = 1'b0, ack, master_n = 1'b1;
	logic ready = 1'b1, ext_n = 1'b1, refclk = 1'b0, line_n;
	logic hold_req, addr_enable_ctl_one_n_n, addr_enable_ctl_two_n_n, upper_oe, grant, stretch, tc_flag;
	logic dclk, tick, out_two, rfsh_o, rfsh_oe, rfsh_sel;
	logic [3:0] dly = 4'h0;
	logic [1:0] wv;
	logic [7:0] exp_q[$];
	logic [7:0] run_len = 8'h0;
	logic p_rst = 1'b1, p_dclk, p_tc, p_two, p_oe = 1'b0, p_grant = 1'b0;
	logic ce = 1'b1, p_ce = 1'b1, p_tk = 1'b0;
	int miscompares = 0, n_compared = 0, seed = 97, rises = 0, ticks = 0;

	// Open-drain refresh line with pull-up
	assign line_n = (rfsh_oe ? rfsh_o : 1'b1) & ext_n;
	assign wv = {hold_req, grant};

	refresh_hold_arbiter DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.ce_i(ce), .dma_i(dma), .counter_one_out_i(cnt_one),
		.counter_two_state_i(cnt_two), .hold_ack_in_i(ack),
		.external_master_n_i(master_n), .channel_ready_i(ready),
		.refresh_n_i(line_n), .counter_ref_clock_i(refclk),
		.hold_request_out_o(hold_req), .addr_enable_ctl_one_n_o(addr_enable_ctl_one_n_n),
		.addr_enable_ctl_two_n_o(addr_enable_ctl_two_n_n), .upper_addr_oe_o(upper_oe),
		.dma_grant_o(grant), .strobe_stretch_o(stretch),
		.terminal_count_flag_o(tc_flag), .dma_clk_en_o(dclk),
		.counter_ref_tick_o(tick), .counter_two_out_o(out_two),
		.refresh_n_o(rfsh_o), .refresh_n_oe_o(rfsh_oe),
		.refresh_sel_o(rfsh_sel));

	host_cpu_model CPU (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.hold_request_i(hold_req), .dly_i(dly), .hold_ack_o(ack));

	always #2 clk_sys_i = ~clk_sys_i;
	always #420 refclk = ~refclk;
	always @(posedge refclk) if (!sys_rst_i) rises++;
	always @(posedge clk_sys_i) {dly, cnt_two} <= 5'($random(seed));

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Bounded wait on grant (0) or hold request (1)
	task automatic wait_for(input int b, input logic v);
		int i;
		for (i = 0; i < 200 && wv[b] !== v; i++) @(posedge clk_sys_i);
		cmp(8'(wv[b]), 8'(v));
	endtask

	// Output watcher
	always @(negedge clk_sys_i) begin
		if (!sys_rst_i && !p_rst) begin
			cmp(8'(dclk), 8'(p_ce ? !p_dclk : p_dclk));
			if (grant) cmp(8'(upper_oe), 8'h01);
			cmp(8'(tc_flag), 8'(p_tc));
			cmp(8'(out_two), 8'(p_two));
			if (!addr_enable_ctl_one_n_n || !addr_enable_ctl_two_n_n) cmp(8'(ack && master_n), 8'h01);
			if (rfsh_oe) cmp({5'h0, ack, rfsh_o, rfsh_sel}, 8'h05);
			if (grant && !p_grant) cmp({6'h0, !addr_enable_ctl_two_n_n, !addr_enable_ctl_one_n_n}, exp_q.pop_front());
			if (!rfsh_oe && p_oe) cmp(run_len, exp_q.pop_front());
			if (tick && !p_tk) ticks++;
		end
		run_len = rfsh_oe ? run_len + 8'h1 : 8'h0;
		p_rst = sys_rst_i;
		p_dclk = dclk;
		p_tc = ce ? (grant && (dma.tc_one || dma.tc_two)) : tc_flag;
		p_two = ce ? cnt_two : out_two;
		p_ce = ce;
		p_tk = tick;
		p_oe = rfsh_oe;
		p_grant = grant;
	end

	initial begin
		repeat (5) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		@(negedge clk_sys_i);
		cmp({2'h0, hold_req, addr_enable_ctl_one_n_n, addr_enable_ctl_two_n_n, rfsh_oe, grant, tc_flag}, 8'h18);
		// Refresh alone, then refresh racing a DMA request
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys_i);
			exp_q.push_back(8'(refresh_hold_pkg::REFRESH_CYC));
			if (k == 2) exp_q.push_back(8'h01);
			cnt_one <= 1'b1;
			dma.req_one <= (k == 2);
			repeat (4) @(posedge clk_sys_i);
			cnt_one <= 1'b0;
			wait_for(k == 2 ? 0 : 1, 1'b1);
			dma.req_one <= 1'b0;
			wait_for(1, 1'b0);
			repeat (10) @(posedge clk_sys_i);
		end
		// Each controller owns the bus with stretch and terminal count
		for (int k = 1; k < 3; k++) begin
			exp_q.push_back(8'(k));
			dma.req_one <= (k == 1);
			dma.req_two <= (k == 2);
			wait_for(0, 1'b1);
			ready <= 1'b0;
			dma.tc_one <= (k == 1);
			dma.tc_two <= (k == 2);
			@(posedge clk_sys_i);
			dma.tc_one <= 1'b0;
			dma.tc_two <= 1'b0;
			repeat (6) @(posedge clk_sys_i);
			cmp(8'(stretch), 8'h01);
			ready <= 1'b1;
			repeat (6) @(posedge clk_sys_i);
			cmp(8'(stretch), 8'h00);
			dma.req_one <= 1'b0;
			dma.req_two <= 1'b0;
			wait_for(0, 1'b0);
			wait_for(1, 1'b0);
			repeat (10) @(posedge clk_sys_i);
		end
		// External master locks out DMA
		master_n <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		dma.req_one <= 1'b1;
		repeat (30) @(posedge clk_sys_i);
		cmp({5'h0, grant, addr_enable_ctl_one_n_n && addr_enable_ctl_two_n_n, upper_oe}, 8'h02);
		dma.req_one <= 1'b0;
		wait_for(1, 1'b0);
		repeat (8) @(posedge clk_sys_i);
		master_n <= 1'b1;
		// Refresh timing from an outside source
		ext_n <= 1'b0;
		repeat (6) @(posedge clk_sys_i);
		cmp({6'h0, rfsh_sel, rfsh_oe}, 8'h02);
		ext_n <= 1'b1;
		repeat (6) @(posedge clk_sys_i);
		// Clock enable low freezes all state
		ce <= 1'b0;
		repeat (5) @(posedge clk_sys_i);
		ce <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		cmp(8'((rises - ticks) inside {0, 1}), 8'h01);
		results();
	end

	// Watchdog: the tests need a few hundred cycles
	initial begin
		#100000;
		miscompares++;
		results();
	end
endmodule
